// *** core/ddc_pkg.sv ***
// Purpose: Shared constants and carriers for the dual DAC clear/load/lockout control
// Assumes: 32-bit serial command words, two channels, 16-bit codes
// Notes: Field positions are bit indices into the received word
package ddc_pkg;
   // Word layout
   localparam int WORD_BITS = 32;
   localparam int CNT_W = 6;
   localparam int CODE_W = 16;
   localparam int NUM_CH = 2;
   localparam int CMD_HI = 27;
   localparam int CMD_LO = 24;
   localparam int ADDR_HI = 23;
   localparam int ADDR_LO = 20;
   localparam int DATA_HI = 19;
   localparam int DATA_LO = 4;
   localparam int PD_HI = 9;
   localparam int PD_LO = 8;
   localparam int SEL_B = 3;
   localparam int SEL_A = 0;
   localparam int CLR_HI = 1;
   localparam int CLR_LO = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Command and address patterns
   localparam logic [3:0] CMD_WRITE = 4'h0;
   localparam logic [3:0] CMD_PWRDN = 4'h4;
   localparam logic [3:0] CMD_CLRCODE = 4'h5;
   localparam logic [3:0] CMD_OVERRIDE = 4'h6;
   localparam logic [3:0] ADDR_ALL = 4'hf;
   // Clear code selections and their codes
   localparam logic [1:0] CLR_ZERO = 2'h0;
   localparam logic [1:0] CLR_MID = 2'h1;
   localparam logic [1:0] CLR_FULL = 2'h2;
   localparam logic [1:0] CLR_NOP = 2'h3;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;
   localparam logic [1:0] PD_NORMAL = 2'h0;
   // Reset values
   localparam logic [1:0] RST_CLEAR_SEL = 2'h0;
   localparam logic [1:0] RST_OVERRIDE = 2'h0;
   localparam logic [15:0] RST_CODE = 16'h0000;
   ////////////////////////////////////////////////////////////////////////////
   // Asynchronous inputs gathered for one synchroniser
   typedef struct packed {
      logic lockoutN;
      logic clearN;
      logic loadN;
      logic frameN;
      logic wordToggle;
   } ddc_pins_s;
   // Per-channel register state
   typedef struct packed {
      logic [15:0] inputCode;
      logic [15:0] dacCode;
      logic [1:0] pdMode;
   } ddc_chan_s;
endpackage : ddc_pkg

// *** core/ddc_sync2.sv ***
// Purpose: Two-flop synchroniser for a group of level signals
// Assumes: Each bit changes slowly against clk_sys
// Notes: Stage one feeds only stage two
`timescale 1ns/1ps
`default_nettype none
module ddc_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // Next stage values
   always_comb begin
      meta_d = asyncIn;
      sync_d = meta_q;
   end

   // Reset high so that active-low pins look idle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign syncOut = sync_q;
endmodule : ddc_sync2
`default_nettype wire

// *** core/ddc_link_rx.sv ***
// Purpose: Serial word receiver on the link clock
// Assumes: Data valid at the falling serial clock edge, MSB first
// Notes: Completed word held stable until the next word completes
`timescale 1ns/1ps
`default_nettype none
module ddc_link_rx (
   input wire logic sclk,
   input wire logic rst_b,
   input wire logic frameN,
   input wire logic dataIn,
   output logic [31:0] wordOut,
   output logic wordToggle
);
   logic [ddc_pkg::CNT_W-1:0] cnt_q;
   logic [ddc_pkg::CNT_W-1:0] cnt_d;
   logic [31:0] shift_q;
   logic [31:0] shift_d;
   logic [31:0] word_q;
   logic [31:0] word_d;
   logic tog_q;
   logic tog_d;
   logic lastBit;

   // Shift until 32 bits are in, extra bits are ignored
   always_comb begin
      lastBit = (cnt_q == ddc_pkg::CNT_W'(ddc_pkg::WORD_BITS - 1));
      cnt_d = cnt_q;
      shift_d = shift_q;
      word_d = word_q;
      tog_d = tog_q;
      if (cnt_q < ddc_pkg::CNT_W'(ddc_pkg::WORD_BITS)) begin
         cnt_d = cnt_q + 1'b1;
         shift_d = {shift_q[30:0], dataIn};
      end
      if (lastBit) begin
         word_d = {shift_q[30:0], dataIn};
         tog_d = ~tog_q;
      end
   end

   // Frame high clears the count; clock may stop between frames
   always_ff @(negedge sclk or negedge rst_b or posedge frameN) begin
      if (!rst_b) begin
         cnt_q <= '0;
         shift_q <= '0;
      end else if (frameN) begin
         cnt_q <= '0;
         shift_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         shift_q <= shift_d;
      end
   end

   // Word and event toggle survive frame end
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         word_q <= '0;
         tog_q <= 1'b0;
      end else begin
         word_q <= word_d;
         tog_q <= tog_d;
      end
   end

   assign wordOut = word_q;
   assign wordToggle = tog_q;
endmodule : ddc_link_rx
`default_nettype wire

// *** core/ddc_lockout_ctrl.sv ***
// Purpose: Command handling for clear code, load override and power-down lockout
// Assumes: Pins asynchronous to clk_sys; serial link on its own clock
// Notes: Pin and word events seen two to three clk_sys cycles late
`timescale 1ns/1ps
`default_nettype none
module ddc_lockout_ctrl (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic frameSyncN,
   input wire logic serialDataIn,
   input wire logic shutdownLockoutPinN,
   input wire logic asyncClearPinN,
   input wire logic loadUpdatePinN,
   output logic [15:0] dacCodeA,
   output logic [15:0] dacCodeB,
   output logic [1:0] pdModeA,
   output logic [1:0] pdModeB,
   output logic [1:0] clearCodeSel,
   output logic [1:0] loadOverrideMask,
   output logic writeAborted
);
   ////////////////////////////////////////////////////////////////////////////
   // Link receiver and crossing
   logic [31:0] linkWord;
   logic linkToggle;
   ddc_pkg::ddc_pins_s pinsRaw;
   ddc_pkg::ddc_pins_s pinsCur;
   ddc_pkg::ddc_pins_s prev_q;
   ddc_pkg::ddc_pins_s prev_d;

   ddc_link_rx u_rx (
      .sclk(sclk),
      .rst_b(rst_b),
      .frameN(frameSyncN),
      .dataIn(serialDataIn),
      .wordOut(linkWord),
      .wordToggle(linkToggle)
   );

   // Pins and word toggle cross as levels
   // Toggle goes inverted so that its reset level matches the all-ones reset of
   // the synchroniser and of prev_q; otherwise a false word event follows reset
   assign pinsRaw = '{lockoutN: shutdownLockoutPinN, clearN: asyncClearPinN,
                      loadN: loadUpdatePinN, frameN: frameSyncN, wordToggle: ~linkToggle};

   ddc_sync2 #(.W($bits(ddc_pkg::ddc_pins_s))) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .asyncIn(pinsRaw),
      .syncOut(pinsCur)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge events and word fields
   logic lockFall;
   logic lockRise;
   logic clearFall;
   logic loadFall;
   logic frameStart;
   logic wordEvt;
   logic abortNow;
   logic wordOk;
   logic [3:0] cmd;
   logic [3:0] addr;
   logic [15:0] data;
   logic [15:0] clrValue;
   logic [1:0] clearCode_q;
   logic [1:0] clearCode_d;

   // Word stays stable long after its toggle, so sampling here is safe
   always_comb begin
      prev_d = pinsCur;
      lockFall = prev_q.lockoutN & ~pinsCur.lockoutN;
      lockRise = ~prev_q.lockoutN & pinsCur.lockoutN;
      clearFall = prev_q.clearN & ~pinsCur.clearN;
      loadFall = prev_q.loadN & ~pinsCur.loadN;
      frameStart = prev_q.frameN & ~pinsCur.frameN;
      wordEvt = prev_q.wordToggle ^ pinsCur.wordToggle;
      cmd = linkWord[ddc_pkg::CMD_HI:ddc_pkg::CMD_LO];
      addr = linkWord[ddc_pkg::ADDR_HI:ddc_pkg::ADDR_LO];
      data = linkWord[ddc_pkg::DATA_HI:ddc_pkg::DATA_LO];
   end

   // Selected clear code; pattern 11 loads nothing
   always_comb begin
      case (clearCode_q)
         ddc_pkg::CLR_ZERO: clrValue = ddc_pkg::CODE_ZERO;
         ddc_pkg::CLR_MID: clrValue = ddc_pkg::CODE_MID;
         ddc_pkg::CLR_FULL: clrValue = ddc_pkg::CODE_FULL;
         default: clrValue = ddc_pkg::CODE_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Abort tracking and global registers
   logic abort_q;
   logic abort_d;
   logic abortOut_q;
   logic abortOut_d;
   logic [1:0] override_q;
   logic [1:0] override_d;

   // Cleared at frame start, not end, so a late word of an aborted frame is still dropped
   always_comb begin
      abortNow = (lockFall | clearFall) & ~pinsCur.frameN;
      abort_d = abort_q;
      if (frameStart) begin
         abort_d = 1'b0;
      end
      if (abortNow) begin
         abort_d = 1'b1;
      end
      abortOut_d = abortNow;
      wordOk = wordEvt & ~abort_q & ~abortNow;
      clearCode_d = clearCode_q;
      override_d = override_q;
      if (wordOk && cmd == ddc_pkg::CMD_CLRCODE) begin
         clearCode_d = linkWord[ddc_pkg::CLR_HI:ddc_pkg::CLR_LO];
      end
      if (wordOk && cmd == ddc_pkg::CMD_OVERRIDE) begin
         override_d = {linkWord[ddc_pkg::SEL_B], linkWord[ddc_pkg::SEL_A]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= '1;
         abort_q <= 1'b0;
         abortOut_q <= 1'b0;
         clearCode_q <= ddc_pkg::RST_CLEAR_SEL;
         override_q <= ddc_pkg::RST_OVERRIDE;
      end else begin
         prev_q <= prev_d;
         abort_q <= abort_d;
         abortOut_q <= abortOut_d;
         clearCode_q <= clearCode_d;
         override_q <= override_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel input, DAC and power-down state
   ddc_pkg::ddc_chan_s chan_q [ddc_pkg::NUM_CH];

   for (genvar i = 0; i < ddc_pkg::NUM_CH; i++) begin : g_ch
      localparam int SEL = (i == 0) ? ddc_pkg::SEL_A : ddc_pkg::SEL_B;
      ddc_pkg::ddc_chan_s c_d;
      logic addrHit;

      // Clear with a code other than 11 blocks load and write; otherwise load pin, then serial write on top
      always_comb begin
         addrHit = (addr == 4'(i)) || (addr == ddc_pkg::ADDR_ALL);
         c_d = chan_q[i];
         if (clearFall && clearCode_q != ddc_pkg::CLR_NOP) begin
            c_d.inputCode = clrValue;
            c_d.dacCode = clrValue;
         end else begin
            if (loadFall && !override_q[i]) begin
               c_d.dacCode = chan_q[i].inputCode;
            end
            if (wordOk && cmd == ddc_pkg::CMD_WRITE && addrHit) begin
               c_d.inputCode = data;
               if (override_q[i] || !pinsCur.loadN) begin
                  c_d.dacCode = data;
               end
            end
            if (wordOk && cmd == ddc_pkg::CMD_PWRDN && linkWord[SEL] && pinsCur.lockoutN) begin
               c_d.pdMode = linkWord[ddc_pkg::PD_HI:ddc_pkg::PD_LO];
            end
         end
         // Lockout falling, or clear while locked out, powers every channel up
         if (lockFall || (clearFall && !pinsCur.lockoutN)) begin
            c_d.pdMode = ddc_pkg::PD_NORMAL;
         end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            chan_q[i] <= '{inputCode: ddc_pkg::RST_CODE, dacCode: ddc_pkg::RST_CODE,
                           pdMode: ddc_pkg::PD_NORMAL};
         end else begin
            chan_q[i] <= c_d;
         end
      end
   end

   // Outputs straight from registers
   assign dacCodeA = chan_q[0].dacCode;
   assign dacCodeB = chan_q[1].dacCode;
   assign pdModeA = chan_q[0].pdMode;
   assign pdModeB = chan_q[1].pdMode;
   assign clearCodeSel = clearCode_q;
   assign loadOverrideMask = override_q;
   assign writeAborted = abortOut_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   sequence s_abortSeen;
      abortNow ##1 abort_q;
   endsequence
   sequence s_staleWord;
      wordEvt && abort_q && !frameStart;
   endsequence

   property p_abort_drops;
      s_staleWord |=> $stable(clearCode_q) && $stable(override_q);
   endproperty
   a_abort_drops: assert property (p_abort_drops) else $error("aborted word was applied");

   property p_clear_mid;
      clearFall && clearCode_q == 2'h1 |=> dacCodeA == 16'h8000 && dacCodeB == 16'h8000;
   endproperty
   a_clear_mid: assert property (p_clear_mid) else $error("clear to midscale failed");

   property p_clear_wins;
      clearFall && loadFall && clearCode_q == 2'h2 |=> chan_q[0].inputCode == 16'hffff && dacCodeA == 16'hffff;
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("load beat clear");

   property p_lock_powerup;
      lockFall |=> pdModeA == 2'h0 && pdModeB == 2'h0;
   endproperty
   a_lock_powerup: assert property (p_lock_powerup) else $error("lockout kept power-down");

   property p_lock_blocks;
      !pinsCur.lockoutN |=> pdModeA == 2'h0 || pdModeA == $past(pdModeA);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("power-down taken under lockout");

   property p_override_upd;
      wordOk && cmd == ddc_pkg::CMD_WRITE && (addr == 4'h0 || addr == ddc_pkg::ADDR_ALL) && override_q[0]
         && !clearFall |=> dacCodeA == $past(data);
   endproperty
   a_override_upd: assert property (p_override_upd) else $error("override write missed");

   property p_pin_holds;
      !override_q[0] && pinsCur.loadN && !loadFall && !clearFall |=> dacCodeA == $past(dacCodeA);
   endproperty
   a_pin_holds: assert property (p_pin_holds) else $error("output moved with load high");

   property p_load_copy;
      loadFall && !override_q[0] && !clearFall && !wordOk |=> dacCodeA == $past(chan_q[0].inputCode);
   endproperty
   a_load_copy: assert property (p_load_copy) else $error("load edge did not copy");

   property p_clr_code;
      wordOk && cmd == 4'h5 |=> clearCodeSel == $past(linkWord[1:0]);
   endproperty
   a_clr_code: assert property (p_clr_code) else $error("clear code not stored");

   property p_ovr_mask;
      wordOk && cmd == 4'h6 |=> loadOverrideMask == {$past(linkWord[3]), $past(linkWord[0])};
   endproperty
   a_ovr_mask: assert property (p_ovr_mask) else $error("override mask not stored");

   property p_rise_normal;
      lockRise && !wordEvt |=> pdModeA == $past(pdModeA) && pdModeB == $past(pdModeB);
   endproperty
   a_rise_normal: assert property (p_rise_normal) else $error("lockout release changed mode");

   // Abort is reported in the cycle the drop flag is set
   property p_abort_pulse;
      s_abortSeen |-> writeAborted;
   endproperty
   a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse missing");

   // Clear under a held lockout still powers every channel up
   property p_clr_lock_up;
      clearFall && !pinsCur.lockoutN |=> pdModeA == ddc_pkg::PD_NORMAL && pdModeB == ddc_pkg::PD_NORMAL;
   endproperty
   a_clr_lock_up: assert property (p_clr_lock_up) else $error("clear under lockout kept power-down");

   // Accepted power-down word selecting channel A sets channel A's mode
   property p_pd_take;
      wordOk && cmd == ddc_pkg::CMD_PWRDN && linkWord[ddc_pkg::SEL_A] && pinsCur.lockoutN && !clearFall
         |=> pdModeA == $past(linkWord[ddc_pkg::PD_HI:ddc_pkg::PD_LO]);
   endproperty
   a_pd_take: assert property (p_pd_take) else $error("power-down word not applied");

   // Frame start ends the drop window unless a new abort lands with it
   property p_frame_clears;
      frameStart && !abortNow |=> !abort_q;
   endproperty
   a_frame_clears: assert property (p_frame_clears) else $error("drop window outlived frame start");
endmodule : ddc_lockout_ctrl
`default_nettype wire

// *** verif/ddc_host_model.sv ***
// Purpose: Host serial port model driving 32-bit command words
// Assumes: Serial clock idles low, data changes on the rising edge
// Notes: Serial clock stands still outside frames
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
   output logic sclk,
   output logic frameSyncN,
   output logic dataIn
);
   localparam int HALF = 80;
   ////////////////////////////////////////////////////////////////////////////
   // Idle levels at time zero
   initial begin
      sclk = 1'b0;
      frameSyncN = 1'b1;
      dataIn = 1'b0;
   end
   // Odd start offset keeps frames off the system clock grid
   task automatic open_frame();
      #37;
      frameSyncN = 1'b0;
      #HALF;
   endtask : open_frame
   // Bits hi down to lo, each stable across its falling edge
   task automatic send_bits(input logic [31:0] w, input int hi, input int lo);
      for (int i = hi; i >= lo; i--) begin
         sclk = 1'b1;
         dataIn = w[i];
         #HALF;
         sclk = 1'b0;
         #HALF;
      end
   endtask : send_bits
   // Released line shows inverse of last bit, not a stale value
   task automatic close_frame();
      frameSyncN = 1'b1;
      dataIn = ~dataIn;
      #200;
   endtask : close_frame
   // Whole word in one frame
   task automatic send_word(input logic [31:0] w);
      open_frame();
      send_bits(w, 31, 0);
      close_frame();
   endtask : send_word
endmodule : ddc_host_model
`default_nettype wire

// *** verif/dual_dac_clear_load_lockout_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for clear code, load override and lockout
// Assumes: Pins driven on falling clk_sys, host model on its own clock
// Notes: Waits after each word cover sync latency of the pins and link
`timescale 1ns/1ps
`default_nettype none
module dual_dac_clear_load_lockout_ctrl_tb_top;
   logic clkSys, rstB, lockoutN, clearN, loadN, sclk, frameSyncN, serialData, writeAborted;
   logic [15:0] dacCodeA, dacCodeB;
   logic [1:0] pdModeA, pdModeB, clearCodeSel, loadOverrideMask;
   int badCount = 0;
   int nTests = 0;
   int abortCnt = 0;
   int cycles = 0;
   logic [1:0] sels [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
   logic [15:0] codeTab [3] = '{ddc_pkg::CODE_ZERO, ddc_pkg::CODE_MID, ddc_pkg::CODE_FULL};
   ddc_lockout_ctrl DUT (.clk_sys(clkSys), .rst_b(rstB), .sclk(sclk), .frameSyncN(frameSyncN),
      .serialDataIn(serialData), .shutdownLockoutPinN(lockoutN), .asyncClearPinN(clearN),
      .loadUpdatePinN(loadN), .dacCodeA(dacCodeA), .dacCodeB(dacCodeB), .pdModeA(pdModeA),
      .pdModeB(pdModeB), .clearCodeSel(clearCodeSel), .loadOverrideMask(loadOverrideMask),
      .writeAborted(writeAborted));
   ddc_host_model HOST (.sclk(sclk), .frameSyncN(frameSyncN), .dataIn(serialData));
   ////////////////////////////////////////////////////////////////////////////
   // Word builders
   function automatic logic [31:0] wrWord(input logic [3:0] a, input logic [15:0] d);
      return {4'h0, ddc_pkg::CMD_WRITE, a, d, 4'h0};
   endfunction : wrWord
   function automatic logic [31:0] clrWord(input logic [1:0] s);
      return {4'hf, 4'h5, 4'ha, 18'h3fff0, s};
   endfunction : clrWord
   // Spare low bits set to show they are ignored
   function automatic logic [31:0] ovrWord(input logic b, input logic a);
      return {4'h0, 4'h6, 4'hf, 16'h0, b, 2'h3, a};
   endfunction : ovrWord
   function automatic logic [31:0] pdWord(input logic [1:0] m, input logic b, input logic a);
      return {4'h0, 4'h4, 4'h0, 10'h0, m, 4'h0, b, 2'h0, a};
   endfunction : pdWord
   ////////////////////////////////////////////////////////////////////////////
   // Clock, abort pulse counter and hang guard
   initial begin
      clkSys = 1'b0;
      forever #20 clkSys = ~clkSys;
   end
   always @(posedge clkSys) begin
      if (writeAborted === 1'b1) abortCnt++;
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         endSim();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clkSys);
   endtask : cyc
   task automatic send(input logic [31:0] w);
      HOST.send_word(w);
      cyc(8);
   endtask : send
   task automatic pulseClear();
      clearN = 1'b0;
      cyc(6);
      clearN = 1'b1;
      cyc(4);
   endtask : pulseClear
   task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH %0t code %h expected %h", $time, got, exp);
      end
   endtask : chk_code
   task automatic chk_bits(input logic [1:0] got, input logic [1:0] exp);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH %0t field %h expected %h", $time, got, exp);
      end
   endtask : chk_bits
   task automatic endSim();
      $display("Checks %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : endSim
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [15:0] prev;
      logic [1:0] s;
      rstB = 1'b0;
      lockoutN = 1'b1;
      clearN = 1'b1;
      loadN = 1'b1;
      cyc(8);
      rstB = 1'b1;
      cyc(4);
      chk_code(dacCodeA, ddc_pkg::RST_CODE);
      chk_bits(clearCodeSel, ddc_pkg::CLR_ZERO);
      // Load pin low: update lands at word end
      loadN = 1'b0;
      send(wrWord(4'hf, 16'h1234));
      chk_code(dacCodeB, 16'h1234);
      // Every clear selection, no-op first so old code must survive
      prev = 16'h1234;
      for (int i = 0; i < 4; i++) begin
         s = sels[i];
         send(clrWord(s));
         chk_bits(clearCodeSel, s);
         pulseClear();
         if (s != ddc_pkg::CLR_NOP) prev = codeTab[s];
         chk_code(dacCodeA, prev);
         chk_code(dacCodeB, prev);
      end
      // Override per channel with load pin high
      loadN = 1'b1;
      send(ovrWord(1'b0, 1'b1));
      chk_bits(loadOverrideMask, 2'h1);
      send(wrWord(4'hf, 16'habcd));
      chk_code(dacCodeA, 16'habcd);
      chk_code(dacCodeB, 16'h0000);
      loadN = 1'b0;
      cyc(5);
      chk_code(dacCodeB, 16'habcd);
      loadN = 1'b1;
      send(ovrWord(1'b1, 1'b0));
      chk_bits(loadOverrideMask, 2'h2);
      send(wrWord(4'hf, 16'h4321));
      chk_code(dacCodeB, 16'h4321);
      chk_code(dacCodeA, 16'habcd);
      // Power-down against lockout
      send(pdWord(2'h2, 1'b1, 1'b1));
      chk_bits(pdModeA, 2'h2);
      chk_bits(pdModeB, 2'h2);
      lockoutN = 1'b0;
      cyc(5);
      chk_bits(pdModeA, ddc_pkg::PD_NORMAL);
      chk_bits(pdModeB, ddc_pkg::PD_NORMAL);
      chk_code(dacCodeA, 16'habcd);
      send(pdWord(2'h3, 1'b1, 1'b1));
      chk_bits(pdModeB, ddc_pkg::PD_NORMAL);
      lockoutN = 1'b1;
      cyc(5);
      chk_bits(pdModeA, ddc_pkg::PD_NORMAL);
      send(pdWord(2'h1, 1'b0, 1'b1));
      chk_bits(pdModeA, 2'h1);
      chk_bits(pdModeB, 2'h0);
      // Lockout falls mid-word: rest of frame must be discarded
      HOST.open_frame();
      HOST.send_bits(wrWord(4'h1, 16'h5a5a), 31, 16);
      @(negedge clkSys);
      lockoutN = 1'b0;
      cyc(6);
      HOST.send_bits(wrWord(4'h1, 16'h5a5a), 15, 0);
      HOST.close_frame();
      cyc(8);
      chk_bits(2'(abortCnt), 2'h1);
      chk_code(dacCodeB, 16'h4321);
      send(wrWord(4'h1, 16'h5a5a));
      chk_code(dacCodeB, 16'h5a5a);
      lockoutN = 1'b1;
      cyc(4);
      // Clear, load and lockout together
      send(pdWord(2'h2, 1'b1, 1'b1));
      send(clrWord(ddc_pkg::CLR_FULL));
      send(ovrWord(1'b0, 1'b0));
      chk_bits(loadOverrideMask, 2'h0);
      send(wrWord(4'hf, 16'h1111));
      chk_code(dacCodeA, 16'habcd);
      @(negedge clkSys);
      clearN = 1'b0;
      loadN = 1'b0;
      lockoutN = 1'b0;
      cyc(6);
      chk_code(dacCodeA, ddc_pkg::CODE_FULL);
      chk_code(dacCodeB, ddc_pkg::CODE_FULL);
      chk_bits(pdModeA, ddc_pkg::PD_NORMAL);
      chk_bits(pdModeB, ddc_pkg::PD_NORMAL);
      clearN = 1'b1;
      cyc(4);
      // Clear mid-word aborts even with the no-op code; load low would expose a leak
      send(clrWord(ddc_pkg::CLR_NOP));
      chk_bits(clearCodeSel, ddc_pkg::CLR_NOP);
      HOST.open_frame();
      HOST.send_bits(wrWord(4'hf, 16'h2222), 31, 8);
      @(negedge clkSys);
      clearN = 1'b0;
      cyc(6);
      HOST.send_bits(wrWord(4'hf, 16'h2222), 7, 0);
      HOST.close_frame();
      cyc(8);
      chk_bits(2'(abortCnt), 2'h2);
      chk_code(dacCodeA, ddc_pkg::CODE_FULL);
      clearN = 1'b1;
      cyc(4);
      endSim();
   end
endmodule : dual_dac_clear_load_lockout_ctrl_tb_top
`default_nettype wire
